// ===== dv/pfw_host_model.sv
// host processor model driving the power-on and watchdog pins
`timescale 1ns/10ps
`default_nettype none
module pfw_host_model (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic power_req_i,
	input wire logic wd_toggle_i,
	output logic power_on_pin_o,
	output logic watchdog_pin_o
);
	// pins move just after an edge, like a host gpio
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			power_on_pin_o <= 1'b0;
			watchdog_pin_o <= 1'b0;
		end
		else
		begin
			power_on_pin_o <= power_req_i;
			if (wd_toggle_i)
				watchdog_pin_o <= ~watchdog_pin_o;
		end
	end
endmodule : pfw_host_model
`default_nettype wire

// ===== dv/test_pfw_fault_sm.sv
// self-checking bench of the fault state logic
`include "pfw_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module test_pfw_fault_sm;
	localparam int DBNC_LONG = 20;
	logic ref_clk, rstn, wr_s, rd_s, thr, bk, ov, tsd, wd_exp, st_done, powerup_failure_flag, pu_done, pd_done;
	logic f_en, f_sdwn, pwr_req, wd_tog, pin_pwr, pin_wd, reg_en, bk_en, bias_en, hrst_n, irq;
	logic [1:0] f_dbnc, f_bk;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, d;
	int num_errors, checked, n, e;

	pfw_fault_sm #(.BIAS_MAX_CYC(50), .DBNC_LONG_CYC(DBNC_LONG)) DUT (.ref_clk_i(ref_clk), .rstn_i(rstn),
		.addr_i(addr), .wr_data_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rd_data_o(rdata),
		.input_detect_threshold_i(thr), .backup_cell_input_i(bk), .power_on_pin_i(pin_pwr),
		.watchdog_input_pin_i(pin_wd), .input_overvoltage_event_i(ov), .thermal_shutdown_i(tsd),
		.wd_expire_i(wd_exp), .selftest_done_i(st_done), .powerup_fail_i(powerup_failure_flag), .regulator_fault_i(1'b0),
		.turnoff_request_i(1'b0), .powerup_seq_done_i(pu_done), .powerdown_seq_done_i(pd_done),
		.fuse_overvoltage_monitor_enable_i(f_en), .fuse_overvoltage_shutdown_select_i(f_sdwn),
		.fuse_overvoltage_debounce_select_i(f_dbnc), .fuse_backup_voltage_select_i(f_bk),
		.fuse_power_on_pin_mode_i(1'b0), .regulators_en_o(reg_en), .backup_regulator_en_o(bk_en),
		.core_bias_en_o(bias_en), .host_reset_output_n_o(hrst_n), .overvoltage_irq_o(irq));

	pfw_host_model host (.ref_clk_i(ref_clk), .rstn_i(rstn), .power_req_i(pwr_req), .wd_toggle_i(wd_tog),
		.power_on_pin_o(pin_pwr), .watchdog_pin_o(pin_wd));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	function automatic int dbnc_cyc(input logic [1:0] c);
		if (c == 2'h0)
			return `PFW_T_DBNC0_US * `PFW_CLK_MHZ;
		if (c == 2'h1)
			return `PFW_T_DBNC1_US * `PFW_CLK_MHZ;
		// both long codes scaled down by the parameter
		return DBNC_LONG;
	endfunction : dbnc_cyc

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic stop_test();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge ref_clk);
		wr_s <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge ref_clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask : rd

	task automatic pulse(input int k);
		@(posedge ref_clk);
		case (k)
			0: st_done <= 1'b1;
			1: pu_done <= 1'b1;
			2: pd_done <= 1'b1;
			3: wd_exp <= 1'b1;
			4: powerup_failure_flag <= 1'b1;
			default: wd_tog <= 1'b1;
		endcase
		@(posedge ref_clk);
		{st_done, pu_done, pd_done, wd_exp, powerup_failure_flag, wd_tog} <= '0;
	endtask : pulse

	// polls the state field; the one-cycle states are never waited for
	task automatic wait_st(input logic [10:0] s);
		int k;
		logic [31:0] v;
		k = 0;
		v = '0;
		while (v[26:16] !== s && k < 3000)
		begin
			rd(`PFW_OFF_STATUS, v);
			k++;
		end
		chk(32'(v[26:16]), 32'(s));
	endtask : wait_st

	task automatic flags(input logic [3:0] exp);
		rd(`PFW_OFF_STATUS, d);
		chk(32'(d[3:0]), 32'(exp));
	endtask : flags

	task automatic begin_up();
		pwr_req <= 1'b1;
		wait_st(pfw_pkg::ST_SELFTEST);
		chk(32'(bias_en), 32'h1);
	endtask : begin_up

	task automatic mid_up();
		pulse(0);
		n = 0;
		while (reg_en !== 1'b1 && n < 2000)
		begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk(32'(n <= `PFW_T_FIRST_MAX_US * `PFW_CLK_MHZ), 32'h1);
		wait_st(pfw_pkg::ST_PWRUP);
	endtask : mid_up

	task automatic end_up();
		pulse(1);
		wait_st(pfw_pkg::ST_RUN);
		chk(32'(hrst_n), 32'h1);
		pwr_req <= 1'b0;
	endtask : end_up

	task automatic wd_hit(input logic [3:0] cnt);
		pulse($urandom_range(1) ? 5 : 3);
		wait_st(pfw_pkg::ST_PWRDN);
		chk(32'({reg_en, bk_en}), 32'h1);
		rd(`PFW_OFF_STATUS, d);
		chk(32'(d[11:8]), 32'(cnt));
		pulse(2);
	endtask : wd_hit

	initial
	begin
		{rstn, wr_s, rd_s, thr, bk, ov, tsd, wd_exp, st_done, powerup_failure_flag, pu_done, pd_done, pwr_req, wd_tog} = '0;
		addr = '0;
		wdata = '0;
		num_errors = 0;
		checked = 0;
		void'($urandom(10636));
		f_en = 1'($urandom);
		f_sdwn = 1'($urandom);
		f_dbnc = 2'($urandom);
		f_bk = 2'($urandom_range(3, 1));
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(`PFW_OFF_CTRL, d);
		chk(d & 32'h0F01, 32'h0F00);
		thr <= 1'b1;
		wait_st(pfw_pkg::ST_LPOFF);
		rd(`PFW_OFF_CTRL, d);
		chk(32'({d[0], reg_en}), 32'h0);
		begin_up();
		mid_up();
		end_up();
		rd(`PFW_OFF_CTRL, d);
		chk(32'(d[4:1]), 32'({f_dbnc, f_sdwn, f_en}));
		wr(`PFW_OFF_CTRL, 32'h0202);
		wd_hit(4'h1);
		wait_st(pfw_pkg::ST_SELFTEST);
		mid_up();
		end_up();
		wd_hit(4'h2);
		wait_st(pfw_pkg::ST_LPOFF);
		flags(4'h2);
		wr(`PFW_OFF_STATUS, 32'h0F);
		flags(4'h2);
		begin_up();
		mid_up();
		end_up();
		wr(`PFW_OFF_STATUS, 32'h0F);
		flags(4'h0);
		wr(`PFW_OFF_CTRL, 32'h0F00);
		ov <= 1'b1;
		repeat (200) @(posedge ref_clk);
		#1 chk(32'(irq), 32'h0);
		ov <= 1'b0;
		for (int c = 0; c < 4; c++)
		begin
			wr(`PFW_OFF_CTRL, 32'h0F02 | (32'(c) << 3));
			e = dbnc_cyc(2'(c));
			ov <= 1'b1;
			n = 0;
			while (irq !== 1'b1 && n < 1200)
			begin
				@(posedge ref_clk);
				#1 n++;
			end
			chk(32'(n >= e - 1 && n <= e + 8), 32'h1);
			ov <= 1'b0;
			// the synchroniser still shows the comparator high for a few edges, and set beats clear
			repeat (6) @(posedge ref_clk);
			wr(`PFW_OFF_STATUS, 32'h10);
			#1 chk(32'(irq), 32'h0);
		end
		wr(`PFW_OFF_CTRL, 32'h0F06);
		ov <= 1'b1;
		wait_st(pfw_pkg::ST_PWRDN);
		ov <= 1'b0;
		pulse(2);
		wait_st(pfw_pkg::ST_LPOFF);
		flags(4'h0);
		begin_up();
		mid_up();
		end_up();
		tsd <= 1'b1;
		wait_st(pfw_pkg::ST_PWRDN);
		tsd <= 1'b0;
		pulse(2);
		wait_st(pfw_pkg::ST_LPOFF);
		flags(4'h8);
		begin_up();
		mid_up();
		// a held power-on level would restart power-up straight out of the off state
		pwr_req <= 1'b0;
		pulse(4);
		pd_done <= 1'b1;
		wait_st(pfw_pkg::ST_LPOFF);
		pd_done <= 1'b0;
		flags(4'h9);
		wr(`PFW_OFF_CTRL, 32'h0F01);
		bk <= 1'b1;
		thr <= 1'b0;
		wait_st(pfw_pkg::ST_BACKUP);
		chk(32'(bk_en), 32'(f_bk != 2'h0));
		thr <= 1'b1;
		wait_st(pfw_pkg::ST_LPOFF);
		flags(4'h0);
		rd(`PFW_OFF_CTRL, d);
		chk(32'(d[0]), 32'h0);
		begin_up();
		pwr_req <= 1'b0;
		pd_done <= 1'b1;
		wait_st(pfw_pkg::ST_LPOFF);
		pd_done <= 1'b0;
		flags(4'h1);
		bk <= 1'b0;
		thr <= 1'b0;
		wait_st(pfw_pkg::ST_UNPWR);
		chk(32'({bk_en, reg_en}), 32'h0);
		rd(8'h08, d);
		chk(d, 32'h0);
		stop_test();
	end

	initial
	begin
		repeat (90000) @(posedge ref_clk);
		num_errors++;
		$display("BAD %0t run did not finish", $time);
		stop_test();
	end
endmodule : test_pfw_fault_sm
`default_nettype wire

// ===== hw/pfw_consts.svh
// offsets, field positions, reset values and timing counts of the fault state logic
`ifndef PFW_CONSTS_SVH
`define PFW_CONSTS_SVH
`define PFW_ADDR_W 8
`define PFW_OFF_CTRL 8'h00
`define PFW_OFF_STATUS 8'h04
`define PFW_CTRL_LPOFF_BIT 0
`define PFW_CTRL_OV_EN_BIT 1
`define PFW_CTRL_OV_SDWN_BIT 2
`define PFW_CTRL_DBNC_LSB 3
`define PFW_CTRL_LIMIT_LSB 8
`define PFW_STAT_FLAGS_LSB 0
`define PFW_STAT_OV_IRQ_BIT 4
`define PFW_STAT_CNT_LSB 8
`define PFW_STAT_STATE_LSB 16
`define PFW_FLAG_PU 0
`define PFW_FLAG_WD 1
`define PFW_FLAG_REG 2
`define PFW_FLAG_TSD 3
`define PFW_LIMIT_RST 4'hF
`define PFW_DBNC_RST 2'h0
`define PFW_CLK_MHZ 10
`define PFW_T_BIAS_MAX_US 1500
`define PFW_T_FIRST_MAX_US 100
`define PFW_T_DBNC0_US 10
`define PFW_T_DBNC1_US 100
`define PFW_T_DBNC2_US 1000
`endif

// ===== hw/pfw_fault_sm.sv
// fault, watchdog and startup state logic of the power controller
`include "pfw_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module pfw_fault_sm #(
	parameter int BIAS_MAX_CYC = `PFW_T_BIAS_MAX_US * `PFW_CLK_MHZ,
	parameter int DBNC_LONG_CYC = `PFW_T_DBNC2_US * `PFW_CLK_MHZ
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic [`PFW_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rd_data_o,
	input wire logic input_detect_threshold_i,
	input wire logic backup_cell_input_i,
	input wire logic power_on_pin_i,
	input wire logic watchdog_input_pin_i,
	input wire logic input_overvoltage_event_i,
	input wire logic thermal_shutdown_i,
	input wire logic wd_expire_i,
	input wire logic selftest_done_i,
	input wire logic powerup_fail_i,
	input wire logic regulator_fault_i,
	input wire logic turnoff_request_i,
	input wire logic powerup_seq_done_i,
	input wire logic powerdown_seq_done_i,
	input wire logic fuse_overvoltage_monitor_enable_i,
	input wire logic fuse_overvoltage_shutdown_select_i,
	input wire logic [1:0] fuse_overvoltage_debounce_select_i,
	input wire logic [1:0] fuse_backup_voltage_select_i,
	input wire logic fuse_power_on_pin_mode_i,
	output logic regulators_en_o,
	output logic backup_regulator_en_o,
	output logic core_bias_en_o,
	output logic host_reset_output_n_o,
	output logic overvoltage_irq_o
);
	localparam int FIRST_MAX_CYC = `PFW_T_FIRST_MAX_US * `PFW_CLK_MHZ;

	function automatic logic [15:0] dbnc_cycles(input logic [1:0] code);
		case (code)
			2'h0: dbnc_cycles = 16'(`PFW_T_DBNC0_US * `PFW_CLK_MHZ);
			2'h1: dbnc_cycles = 16'(`PFW_T_DBNC1_US * `PFW_CLK_MHZ);
			default: dbnc_cycles = 16'(DBNC_LONG_CYC);
		endcase
	endfunction : dbnc_cycles

	// pin synchroniser: three stages, a change counts once stages 2 and 3 agree
	logic [5:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
	wire [5:0] pin_raw = {thermal_shutdown_i, input_overvoltage_event_i, watchdog_input_pin_i,
		power_on_pin_i, backup_cell_input_i, input_detect_threshold_i};
	wire [5:0] pin_next = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pin_s1_reg <= 6'h00;
			pin_s2_reg <= 6'h00;
			pin_s3_reg <= 6'h00;
			pin_reg <= 6'h00;
		end
		else
		begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_reg <= pin_next;
		end
	end
	wire vin_ok = pin_reg[0];
	wire cell_ok = pin_reg[1];
	wire power_on_pin = pin_reg[2];
	wire wdpin = pin_reg[3];
	wire ov_raw = pin_reg[4];
	wire tsd = pin_reg[5];

	pfw_pkg::pfw_state_e state_reg, state_next;
	pfw_pkg::pfw_reason_e reason_reg, reason_next;
	logic [3:0] pend_src_reg, pend_src_next;
	logic [3:0] flags_reg, flags_next;
	logic [3:0] wd_cnt_reg, wd_cnt_next;
	logic [3:0] wd_limit_reg;
	logic lpoff_sel_reg, ov_en_reg, ov_sdwn_reg;
	logic [1:0] dbnc_reg;
	logic fuse_ov_en_reg, fuse_ov_sdwn_reg, fuse_pon_mode_reg;
	logic [1:0] fuse_dbnc_reg;
	logic clr_ok_reg, ov_irq_reg, power_on_pin_q_reg, wdpin_q_reg;
	logic [15:0] dbnc_cnt_reg, bias_cnt_reg;

	// bus decode
	wire wr_ctrl = wr_i && (addr_i == `PFW_OFF_CTRL);
	wire wr_stat = wr_i && (addr_i == `PFW_OFF_STATUS);
	wire rd_ctrl = rd_i && (addr_i == `PFW_OFF_CTRL);
	wire rd_stat = rd_i && (addr_i == `PFW_OFF_STATUS);
	wire [31:0] ctrl_word = {20'h00000, wd_limit_reg, 3'h0, dbnc_reg, ov_sdwn_reg, ov_en_reg, lpoff_sel_reg};
	wire [31:0] stat_word = {5'h00, state_reg, 4'h0, wd_cnt_reg, 3'h0, ov_irq_reg, flags_reg};
	wire [31:0] rd_next = rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h00000000);

	// overvoltage debounce; a dropout restarts the count
	wire [15:0] dbnc_lim = dbnc_cycles(dbnc_reg);
	wire ov_active = ov_raw && ov_en_reg;
	wire ov_det = ov_active && (dbnc_cnt_reg == dbnc_lim);
	wire [15:0] dbnc_cnt_next = !ov_active ? 16'h0000 : (ov_det ? dbnc_cnt_reg : dbnc_cnt_reg + 16'h0001);

	// power-up event and watchdog triggers
	wire pon_evt = fuse_pon_mode_reg ? (power_on_pin_q_reg && !power_on_pin) : power_on_pin;
	wire ov_block = ov_det && fuse_ov_sdwn_reg;
	wire pon_valid = pon_evt && !tsd && !ov_block;
	wire wd_hit = (wdpin != wdpin_q_reg) || wd_expire_i;
	wire [3:0] wd_cnt_inc = wd_cnt_reg + 4'h1;
	wire bias_late = (bias_cnt_reg >= 16'(BIAS_MAX_CYC));
	wire cell_mode = cell_ok && (fuse_backup_voltage_select_i != 2'h0);
	wire in_off = (state_reg == pfw_pkg::ST_LPOFF) || (state_reg == pfw_pkg::ST_QPUOFF);
	wire flag_clr_en = clr_ok_reg && wr_stat;
	wire [3:0] flag_clr = flag_clr_en ? wr_data_i[3:0] : 4'h0;

	always_comb
	begin
		state_next = state_reg;
		reason_next = reason_reg;
		pend_src_next = pend_src_reg;
		wd_cnt_next = wd_cnt_reg;
		flags_next = flags_reg & ~flag_clr;
		if (!vin_ok)
		begin
			state_next = cell_mode ? pfw_pkg::ST_BACKUP : pfw_pkg::ST_UNPWR;
			flags_next = 4'h0;
			wd_cnt_next = 4'h0;
		end
		else
		begin
			case (state_reg)
				pfw_pkg::ST_UNPWR, pfw_pkg::ST_BACKUP:
					state_next = pfw_pkg::ST_FUSELOAD;
				pfw_pkg::ST_FUSELOAD:
					state_next = pfw_pkg::ST_LPOFF;
				pfw_pkg::ST_LPOFF, pfw_pkg::ST_QPUOFF:
				begin
					if (pon_valid)
						state_next = pfw_pkg::ST_SELFTEST;
					else if (lpoff_sel_reg)
						state_next = pfw_pkg::ST_QPUOFF;
					else
						state_next = pfw_pkg::ST_LPOFF;
				end
				pfw_pkg::ST_SELFTEST:
				begin
					if (bias_late)
					begin
						state_next = pfw_pkg::ST_PWRDN;
						reason_next = pfw_pkg::RSN_FAULT;
						pend_src_next = 4'h1 << `PFW_FLAG_PU;
					end
					else if (selftest_done_i)
						state_next = pfw_pkg::ST_PWRUP;
				end
				pfw_pkg::ST_PWRUP:
				begin
					if (powerup_fail_i)
					begin
						state_next = pfw_pkg::ST_PWRDN;
						reason_next = pfw_pkg::RSN_FAULT;
						pend_src_next = 4'h1 << `PFW_FLAG_PU;
					end
					else if (ov_block)
					begin
						state_next = pfw_pkg::ST_PWRDN;
						reason_next = pfw_pkg::RSN_OFF;
					end
					else if (powerup_seq_done_i)
						state_next = pfw_pkg::ST_RUN;
				end
				pfw_pkg::ST_RUN:
				begin
					if (tsd || regulator_fault_i)
					begin
						state_next = pfw_pkg::ST_PWRDN;
						reason_next = pfw_pkg::RSN_FAULT;
						pend_src_next = tsd ? (4'h1 << `PFW_FLAG_TSD) : (4'h1 << `PFW_FLAG_REG);
					end
					else if (turnoff_request_i || (ov_det && ov_sdwn_reg))
					begin
						state_next = pfw_pkg::ST_PWRDN;
						reason_next = pfw_pkg::RSN_OFF;
					end
					else if (wd_hit)
						state_next = pfw_pkg::ST_WDRESET;
				end
				pfw_pkg::ST_WDRESET:
				begin
					wd_cnt_next = wd_cnt_inc;
					state_next = pfw_pkg::ST_PWRDN;
					if (wd_cnt_inc == wd_limit_reg)
					begin
						reason_next = pfw_pkg::RSN_FAULT;
						pend_src_next = 4'h1 << `PFW_FLAG_WD;
					end
					else
						reason_next = pfw_pkg::RSN_RESTART;
				end
				pfw_pkg::ST_PWRDN:
				begin
					if (powerdown_seq_done_i)
					begin
						if (reason_reg == pfw_pkg::RSN_FAULT)
							state_next = pfw_pkg::ST_FAULT;
						else if (reason_reg == pfw_pkg::RSN_RESTART)
							state_next = pfw_pkg::ST_SELFTEST;
						else
							state_next = lpoff_sel_reg ? pfw_pkg::ST_QPUOFF : pfw_pkg::ST_LPOFF;
					end
				end
				pfw_pkg::ST_FAULT:
				begin
					flags_next = (flags_reg & ~flag_clr) | pend_src_next;
					state_next = lpoff_sel_reg ? pfw_pkg::ST_QPUOFF : pfw_pkg::ST_LPOFF;
				end
				default:
					state_next = pfw_pkg::ST_UNPWR;
			endcase
		end
	end

	wire load_fuse = (state_reg == pfw_pkg::ST_FUSELOAD);
	wire load_func = in_off && (state_next == pfw_pkg::ST_SELFTEST);
	wire ov_irq_set = ov_det && !ov_sdwn_reg && ((state_reg == pfw_pkg::ST_RUN) || (state_reg == pfw_pkg::ST_PWRUP));
	wire ov_irq_next = ov_irq_set || (ov_irq_reg && !(wr_stat && wr_data_i[`PFW_STAT_OV_IRQ_BIT]));
	wire bias_run = (state_next == pfw_pkg::ST_SELFTEST) && (state_reg != pfw_pkg::ST_PWRDN);
	wire [15:0] bias_cnt_next = (state_reg == pfw_pkg::ST_FUSELOAD) ? 16'h0000 :
		((bias_run && !bias_late) ? bias_cnt_reg + 16'h0001 : bias_cnt_reg);

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= pfw_pkg::ST_UNPWR;
			reason_reg <= pfw_pkg::RSN_OFF;
			pend_src_reg <= 4'h0;
			flags_reg <= 4'h0;
			wd_cnt_reg <= 4'h0;
			ov_irq_reg <= 1'b0;
			dbnc_cnt_reg <= 16'h0000;
			bias_cnt_reg <= 16'h0000;
			power_on_pin_q_reg <= 1'b0;
			wdpin_q_reg <= 1'b0;
			rd_data_o <= 32'h00000000;
		end
		else
		begin
			state_reg <= state_next;
			reason_reg <= reason_next;
			pend_src_reg <= pend_src_next;
			flags_reg <= flags_next;
			wd_cnt_reg <= wd_cnt_next;
			ov_irq_reg <= ov_irq_next;
			dbnc_cnt_reg <= dbnc_cnt_next;
			bias_cnt_reg <= bias_cnt_next;
			power_on_pin_q_reg <= power_on_pin;
			wdpin_q_reg <= wdpin;
			rd_data_o <= rd_next;
		end
	end

	// fuse mirrors and functional settings; a fuse copy waits for the rising crossing
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			fuse_ov_en_reg <= 1'b0;
			fuse_ov_sdwn_reg <= 1'b0;
			fuse_dbnc_reg <= `PFW_DBNC_RST;
			fuse_pon_mode_reg <= 1'b0;
			lpoff_sel_reg <= 1'b0;
			ov_en_reg <= 1'b0;
			ov_sdwn_reg <= 1'b0;
			dbnc_reg <= `PFW_DBNC_RST;
			wd_limit_reg <= `PFW_LIMIT_RST;
			clr_ok_reg <= 1'b0;
		end
		else
		begin
			if (load_fuse)
			begin
				fuse_ov_en_reg <= fuse_overvoltage_monitor_enable_i;
				fuse_ov_sdwn_reg <= fuse_overvoltage_shutdown_select_i;
				fuse_dbnc_reg <= fuse_overvoltage_debounce_select_i;
				fuse_pon_mode_reg <= fuse_power_on_pin_mode_i;
				lpoff_sel_reg <= 1'b0;
			end
			else if (wr_ctrl)
				lpoff_sel_reg <= wr_data_i[`PFW_CTRL_LPOFF_BIT];
			if (load_func)
			begin
				ov_en_reg <= fuse_ov_en_reg;
				ov_sdwn_reg <= fuse_ov_sdwn_reg;
				dbnc_reg <= fuse_dbnc_reg;
			end
			else if (wr_ctrl)
			begin
				ov_en_reg <= wr_data_i[`PFW_CTRL_OV_EN_BIT];
				ov_sdwn_reg <= wr_data_i[`PFW_CTRL_OV_SDWN_BIT];
				dbnc_reg <= wr_data_i[`PFW_CTRL_DBNC_LSB +: 2];
			end
			if (wr_ctrl)
				wd_limit_reg <= wr_data_i[`PFW_CTRL_LIMIT_LSB +: 4];
			if (state_next == pfw_pkg::ST_FAULT)
				clr_ok_reg <= 1'b0;
			else if (state_reg == pfw_pkg::ST_PWRUP && state_next == pfw_pkg::ST_RUN)
				clr_ok_reg <= 1'b1;
		end
	end

	// pin-level outputs follow the next state, the irq output the next irq flag, so they stay flop-driven
	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			regulators_en_o <= 1'b0;
			backup_regulator_en_o <= 1'b0;
			core_bias_en_o <= 1'b0;
			host_reset_output_n_o <= 1'b0;
			overvoltage_irq_o <= 1'b0;
		end
		else
		begin
			regulators_en_o <= (state_next == pfw_pkg::ST_PWRUP) || (state_next == pfw_pkg::ST_RUN)
				|| (state_next == pfw_pkg::ST_WDRESET);
			backup_regulator_en_o <= (state_next != pfw_pkg::ST_UNPWR) &&
				((state_next != pfw_pkg::ST_BACKUP) || cell_mode);
			core_bias_en_o <= (state_next == pfw_pkg::ST_SELFTEST) || (state_next == pfw_pkg::ST_PWRUP)
				|| (state_next == pfw_pkg::ST_RUN) || (state_next == pfw_pkg::ST_QPUOFF);
			host_reset_output_n_o <= (state_next == pfw_pkg::ST_RUN);
			overvoltage_irq_o <= ov_irq_next;
		end
	end

	// checks
	localparam int FIRST_BOUND = FIRST_MAX_CYC;
	AST_WD_COUNT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_WDRESET && vin_ok) |=> (wd_cnt_reg == $past(wd_cnt_reg) + 4'h1))
		else $error("watchdog counter did not step");
	AST_WD_MAX: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_WDRESET && vin_ok && wd_cnt_inc == wd_limit_reg)
		|=> (reason_reg == pfw_pkg::RSN_FAULT && pend_src_reg == 4'h2 && !regulators_en_o))
		else $error("cyclic watchdog failure not taken");
	AST_WD_RESTART: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_WDRESET && vin_ok && wd_cnt_inc != wd_limit_reg)
		|=> (reason_reg == pfw_pkg::RSN_RESTART && !host_reset_output_n_o))
		else $error("hard watchdog reset not taken");
	AST_PDN_OFF: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_PWRDN && vin_ok && powerdown_seq_done_i && reason_reg == pfw_pkg::RSN_OFF)
		|=> in_off)
		else $error("non-fault turn-off did not reach off mode");
	AST_PDN_FAULT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_PWRDN && vin_ok && powerdown_seq_done_i && reason_reg == pfw_pkg::RSN_FAULT)
		|=> ##1 (flags_reg != 4'h0))
		else $error("fault turn-off did not set a flag");
	AST_ONE_FLAG: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_FAULT && vin_ok) |-> $onehot(pend_src_reg))
		else $error("fault source not exactly one");
	AST_FLAG_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(vin_ok && !clr_ok_reg && flags_reg != 4'h0) |=> (flags_reg >= $past(flags_reg) || !vin_ok))
		else $error("fault flags lost while input present");
	AST_OV_SDWN: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_RUN && vin_ok && ov_det && ov_sdwn_reg && !tsd && !regulator_fault_i)
		|=> (state_reg == pfw_pkg::ST_PWRDN) ##1 !regulators_en_o)
		else $error("overvoltage shutdown not started");
	AST_FIRST_SLOT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_SELFTEST && selftest_done_i && vin_ok && !bias_late)
		|-> ##[1:FIRST_BOUND] regulators_en_o)
		else $error("first slot late after self-test");
	AST_LPOFF_CLR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(state_reg == pfw_pkg::ST_FUSELOAD) |=> (!lpoff_sel_reg && state_reg != pfw_pkg::ST_QPUOFF))
		else $error("low-power-off select not cleared");
	COV_RUN: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		state_reg == pfw_pkg::ST_PWRUP ##1 state_reg == pfw_pkg::ST_RUN);
	COV_WATCHDOG_FAILURE_FLAG: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		flags_reg[`PFW_FLAG_WD] && !$past(flags_reg[`PFW_FLAG_WD]));
	COV_BACKUP: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		state_reg == pfw_pkg::ST_BACKUP && backup_regulator_en_o);
	COV_OV_IRQ: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) $rose(overvoltage_irq_o));
endmodule : pfw_fault_sm
`default_nettype wire

// ===== hw/pfw_pkg.sv
// types of the fault state logic
package pfw_pkg;
	typedef enum logic [10:0] {
		ST_UNPWR = 11'h001,
		ST_BACKUP = 11'h002,
		ST_FUSELOAD = 11'h004,
		ST_LPOFF = 11'h008,
		ST_QPUOFF = 11'h010,
		ST_SELFTEST = 11'h020,
		ST_PWRUP = 11'h040,
		ST_RUN = 11'h080,
		ST_WDRESET = 11'h100,
		ST_PWRDN = 11'h200,
		ST_FAULT = 11'h400
	} pfw_state_e;
	typedef enum logic [2:0] {
		RSN_OFF = 3'h1,
		RSN_FAULT = 3'h2,
		RSN_RESTART = 3'h4
	} pfw_reason_e;
endpackage : pfw_pkg
